// File: rtl/mode_six_regs.sv
// Behaviour
// R1: set parity flag on detected parity error
// R2: parity flag sticky until mode write clears
// R3: set CRC flag on write CRC error
// R4: CRC flag sticky until mode write clears
// R5: parity check off unless latency nonzero
// R6: check parity before executing a command
// R7: parity covers act, command pins, address
// R8: cke, odt, cs_n excluded from parity
// R9: select 110 writes mode register six
// R10: controller holds ras, cas, we low
// R11: controller writes zero to bits 21, 17
// R12: spacing field 12:10 gives 4 to 8
// R13: controller programs spacing for its frequency
// R14: spacing minimum is four clocks
// R15: equalization bits must stay 000
// R16: bit 7 enables reference calibration
// R17: bit 6 selects upper or lower range
// R18: bits 5:0 hold calibration value
// R19: controller sets enable with range writes
// R20: reference level may appear on DQ
// R21: controller steps reference by mode writes
// R22: latency code 0 off, 1..3 four-six clocks
// R23: non-persistent mode stops checking on error
// R24: parity flag bit 4, CRC bit 3
// R25: other selects leave register six alone
// R26: reset clears flags, restores defaults
`timescale 1ns/100ps
`default_nettype none
module mode_six_regs
   import mode_six_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire ca_bus_s ca,
   input wire logic crc_error,
   output logic cmd_execute,
   output logic cmd_blocked,
   output logic par_error_flag,
   output logic crc_error_flag,
   output logic [2:0] parity_latency,
   output logic [3:0] parity_latency_clocks,
   output logic persistent_mode,
   output logic [3:0] same_group_column_spacing,
   output logic [2:0] dq_receiver_equalization,
   output logic cal_enable,
   output logic cal_range,
   output logic [5:0] cal_value,
   output logic vref_probe_enable
);

   // ------------------------------------------------------------
   // Command decode
   // ------------------------------------------------------------
   logic parity_bad;
   logic mrs_cmd;
   logic [2:0] sel;
   logic [21:0] op;
   logic check_on;

   ca_parity_check u_parity (
      .ca(ca),
      .parity_bad(parity_bad)
   );

   assign sel = {ca.bg[0], ca.ba};
   assign op = {ca.bg, ca.ba, ca.addr};
   // Command pins low with act high marks a mode write   see R10
   assign mrs_cmd = !ca.cs_n && ca.act_n && !ca.ras_n && !ca.cas_n && !ca.we_n;

   // ------------------------------------------------------------
   // Mode register five subset: latency, persistence, flags
   // ------------------------------------------------------------
   logic [2:0] lat_reg, lat_next;
   logic persist_reg, persist_next;
   logic par_err_reg, par_err_next;
   logic crc_err_reg, crc_err_next;
   logic par_hit;

   // Reserved latency codes are treated as disabled   see R5 see R22
   assign check_on = (lat_reg != LAT_DISABLED) && (lat_reg <= LAT_MAX_CODE)
                     && (persist_reg || !par_err_reg); // see R23
   assign par_hit = check_on && !ca.cs_n && parity_bad;

   always_comb begin
      lat_next = lat_reg;
      persist_next = persist_reg;
      par_err_next = par_err_reg;
      crc_err_next = crc_err_reg;
      if (mrs_cmd && !par_hit && sel == SEL_MODE_FIVE) begin
         lat_next = op[LAT_LSB +: 3];
         persist_next = op[PERSIST_BIT];
         par_err_next = op[PARITY_ERR_BIT]; // see R2 see R24
         crc_err_next = op[CRC_ERR_BIT]; // see R4 see R24
      end
      // Set wins over a clear in the same cycle
      if (par_hit) begin
         par_err_next = 1'b1; // see R1
      end
      if (crc_error) begin
         crc_err_next = 1'b1; // see R3
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         lat_reg <= LAT_DISABLED; // see R5 see R26
         persist_reg <= 1'b0;
         par_err_reg <= 1'b0; // see R26
         crc_err_reg <= 1'b0;
      end else begin
         lat_reg <= lat_next;
         persist_reg <= persist_next;
         par_err_reg <= par_err_next;
         crc_err_reg <= crc_err_next;
      end
   end

   // ------------------------------------------------------------
   // Mode register six
   // ------------------------------------------------------------
   mode_six_s six_reg, six_next;

   always_comb begin
      six_next = six_reg;
      // Bits 21 and 17 are reserved and not stored   see R11
      if (mrs_cmd && !par_hit && sel == SEL_MODE_SIX) begin // see R9 see R25
         six_next.eq = {op[EQ_HIGH_BIT], op[EQ_LOW_LSB +: 2]}; // see R15
         // Reserved spacing codes keep the previous value   see R12
         if (op[SPACING_LSB +: 3] <= SPACING_MAX_CODE) begin
            six_next.spacing = op[SPACING_LSB +: 3];
         end
         six_next.cal_enable = op[CAL_ENABLE_BIT]; // see R16
         six_next.cal_range = op[CAL_RANGE_BIT]; // see R17
         // Only fifty steps exist, so larger codes are ignored   see R18
         if (op[CAL_VALUE_LSB +: 6] <= CAL_VALUE_MAX) begin
            six_next.cal_value = op[CAL_VALUE_LSB +: 6];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         six_reg <= '{eq: EQ_RESET, spacing: SPACING_RESET, cal_enable: CAL_ENABLE_RESET,
                      cal_range: CAL_RANGE_RESET, cal_value: CAL_VALUE_RESET}; // see R26
      end else begin
         six_reg <= six_next;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign cmd_execute = !ca.cs_n && !par_hit; // see R6
   assign cmd_blocked = par_hit;
   assign par_error_flag = par_err_reg;
   assign crc_error_flag = crc_err_reg;
   assign parity_latency = lat_reg;
   assign parity_latency_clocks = (check_on || lat_reg != LAT_DISABLED) && lat_reg <= LAT_MAX_CODE
                                  && lat_reg != LAT_DISABLED ? LAT_BASE_CLOCKS + {1'b0, lat_reg} : 4'h0;
   assign persistent_mode = persist_reg;
   // Four clocks is the floor   see R14
   assign same_group_column_spacing = SPACING_BASE_CLOCKS + {1'b0, six_reg.spacing}; // see R12
   assign dq_receiver_equalization = six_reg.eq;
   assign cal_enable = six_reg.cal_enable;
   assign cal_range = six_reg.cal_range;
   assign cal_value = six_reg.cal_value;
   assign vref_probe_enable = six_reg.cal_enable; // see R20

endmodule : mode_six_regs
`default_nettype wire

// File: rtl/mode_six_pkg.sv
package mode_six_pkg;

   // ------------------------------------------------------------
   // Command pins and field positions
   // ------------------------------------------------------------
   localparam int MR_WIDTH = 22;
   localparam int ADDR_WIDTH = 18;
   localparam logic [2:0] SEL_MODE_FIVE = 3'h5;
   localparam logic [2:0] SEL_MODE_SIX = 3'h6;
   localparam int SEL_LSB = 18;
   localparam int SPACING_LSB = 10;
   localparam int CAL_ENABLE_BIT = 7;
   localparam int CAL_RANGE_BIT = 6;
   localparam int CAL_VALUE_LSB = 0;
   localparam int EQ_HIGH_BIT = 13;
   localparam int EQ_LOW_LSB = 8;
   localparam int PARITY_ERR_BIT = 4;
   localparam int CRC_ERR_BIT = 3;
   localparam int PERSIST_BIT = 9;
   localparam int LAT_LSB = 0;

   // ------------------------------------------------------------
   // Encodings and reset values
   // ------------------------------------------------------------
   localparam logic [2:0] SPACING_MAX_CODE = 3'h4;
   localparam logic [3:0] SPACING_BASE_CLOCKS = 4'h4;
   localparam logic [2:0] LAT_MAX_CODE = 3'h3;
   localparam logic [2:0] LAT_DISABLED = 3'h0;
   localparam logic [3:0] LAT_BASE_CLOCKS = 4'h3;
   localparam logic [2:0] SPACING_RESET = 3'h0;
   localparam logic [2:0] EQ_RESET = 3'h0;
   localparam logic CAL_ENABLE_RESET = 1'b0;
   localparam logic CAL_RANGE_RESET = 1'b0;
   localparam logic [5:0] CAL_VALUE_RESET = 6'h00;
   localparam logic [5:0] CAL_VALUE_MAX = 6'h31;

   typedef struct packed {
      logic cs_n;
      logic act_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic [1:0] bg;
      logic [1:0] ba;
      logic [17:0] addr;
      logic parity;
   } ca_bus_s;

   typedef struct packed {
      logic [2:0] eq;
      logic [2:0] spacing;
      logic cal_enable;
      logic cal_range;
      logic [5:0] cal_value;
   } mode_six_s;

endpackage : mode_six_pkg

// File: rtl/ca_parity_check.sv
`timescale 1ns/100ps
`default_nettype none
module ca_parity_check
   import mode_six_pkg::*;
(
   input wire ca_bus_s ca,
   output logic parity_bad
);
   // Even parity over command and address; cke, odt and cs_n excluded   see R7 see R8
   always_comb begin
      parity_bad = ^{ca.act_n, ca.ras_n, ca.cas_n, ca.we_n, ca.bg, ca.ba, ca.addr, ca.parity};
   end
endmodule : ca_parity_check
`default_nettype wire

// File: sim/controller_model.sv
`timescale 1ns/100ps
`default_nettype none
module controller_model
   import mode_six_pkg::*;
(
   input wire logic core_clk,
   input wire logic go,
   input wire logic bad,
   input wire logic [21:0] op,
   output var ca_bus_s ca
);
   ca_bus_s last_reg = '0;
   always_ff @(posedge core_clk) begin
      last_reg <= ca;
   end
   always_comb begin
      ca = ~last_reg; // Deselected lines must not look stable
      ca.cs_n = 1'b1;
      if (go) begin
         ca = '0;
         ca.act_n = 1'b1;
         {ca.bg, ca.ba, ca.addr} = op & 22'h1C3FFF;
         ca.parity = ^{ca.act_n, ca.bg, ca.ba, ca.addr} ^ bad;
      end
   end
endmodule : controller_model
`default_nettype wire

// File: sim/mode_six_regs_sva.sv
`timescale 1ns/100ps
`default_nettype none
module mode_six_checker
   import mode_six_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire ca_bus_s ca,
   input wire logic crc_error,
   input wire logic cmd_execute,
   input wire logic cmd_blocked,
   input wire logic par_error_flag,
   input wire logic crc_error_flag,
   input wire logic [2:0] parity_latency,
   input wire logic persistent_mode,
   input wire logic [3:0] same_group_column_spacing,
   input wire logic cal_enable,
   input wire logic [5:0] cal_value
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   logic mw;
   logic [2:0] sel;
   assign mw = !ca.cs_n && ca.act_n && !ca.ras_n && !ca.cas_n && !ca.we_n;
   assign sel = {ca.bg[0], ca.ba};
   par_set_a: assert property (cmd_blocked |=> par_error_flag) else $error("par set");
   par_hold_a: assert property (par_error_flag && !(mw && sel == 3'h5) |=> par_error_flag) else $error("par hold");
   crc_set_a: assert property (crc_error |=> crc_error_flag) else $error("crc set");
   crc_hold_a: assert property (crc_error_flag && !(mw && sel == 3'h5) |=> crc_error_flag) else $error("crc hold");
   par_off_a: assert property (parity_latency == 3'h0 |-> !cmd_blocked) else $error("par off");
   block_exec_a: assert property (cmd_blocked |-> !cmd_execute) else $error("exec");
   persist_stop_a: assert property (par_error_flag && !persistent_mode |-> !cmd_blocked) else $error("stop");
   spacing_set_a: assert property (mw && sel == 3'h6 && !cmd_blocked && ca.addr[12:10] <= 3'h4
      |=> same_group_column_spacing == {1'b0, $past(ca.addr[12:10])} + 4'h4) else $error("spacing");
   cal_set_a: assert property (mw && sel == 3'h6 && !cmd_blocked |=> cal_enable == $past(ca.addr[7])) else $error("cal");
   other_sel_a: assert property (mw && sel != 3'h6 |=> $stable(cal_value)) else $error("other");
   cover property (cmd_blocked);
   cover property (mw && sel == 3'h6 && cmd_execute);
   cover property (crc_error_flag && mw && sel == 3'h5);
endmodule : mode_six_checker
bind mode_six_regs mode_six_checker mode_six_checker_inst (.core_clk, .reset_n, .ca, .crc_error, .cmd_execute,
   .cmd_blocked, .par_error_flag, .crc_error_flag, .parity_latency, .persistent_mode, .same_group_column_spacing,
   .cal_enable, .cal_value);
`default_nettype wire

// File: sim/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top
   import mode_six_pkg::*;
;
   logic core_clk = 0, reset_n = 0, go = 0, bad = 0, crc_error = 0;
   logic [21:0] op = '0;
   ca_bus_s ca;
   logic cmd_execute, cmd_blocked, par_error_flag, crc_error_flag, persistent_mode, cal_enable, cal_range;
   logic vref_probe_enable, e_par = 0, e_crc = 0, e_en = 0, e_rg = 0, e_pers = 0;
   logic [2:0] parity_latency, dq_receiver_equalization, e_lat = 0, e_eq = 0;
   logic [3:0] parity_latency_clocks, same_group_column_spacing, e_sp = 4;
   logic [5:0] cal_value, e_val = 0;
   logic [16:0] q[$];
   int bad_count = 0, check_count = 0, cyc = 0;
   wire logic [16:0] obs = {par_error_flag, crc_error_flag, dq_receiver_equalization,
      same_group_column_spacing, cal_enable, cal_range, cal_value};
   controller_model controller_model_inst (.core_clk, .go, .bad, .op, .ca);
   mode_six_regs mode_six_regs_inst (.core_clk, .reset_n, .ca, .crc_error, .cmd_execute, .cmd_blocked,
      .par_error_flag, .crc_error_flag, .parity_latency, .parity_latency_clocks, .persistent_mode,
      .same_group_column_spacing, .dq_receiver_equalization, .cal_enable, .cal_range, .cal_value,
      .vref_probe_enable);
   // ----
   // Driver, scoreboard and verdict
   // ----
   initial forever #50 core_clk = ~core_clk;
   task automatic chk(string n, logic [16:0] seen, logic [16:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", n, exp, seen);
      end
   endtask : chk
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : wrap_up
   function automatic logic [21:0] m6(logic [2:0] sp);
      // Enable set with every range and value write; values above 49 probe the refusal
      return {4'h6, 5'h00, sp, 3'h1, 1'($urandom), 6'($urandom_range(63))};
   endfunction : m6
   // Called at a falling edge; the idle cycle after it keeps go from toggling twice at once
   task automatic cmd(logic [21:0] o, logic b, logic c);
      logic blk;
      blk = b && e_lat != 0 && (!e_par || e_pers);
      go = 1;
      bad = b;
      crc_error = c;
      op = o;
      if (blk) begin
         e_par = 1;
      end else if (o[20:18] == 3'h5) begin
         {e_pers, e_par, e_crc, e_lat} = {o[9], o[4], o[3], o[2:0]};
      end else if (o[20:18] == 3'h6) begin
         e_eq = {o[13], o[9:8]};
         if (o[12:10] <= 3'h4)
            e_sp = 4'(o[12:10]) + 4'h4;
         {e_en, e_rg} = o[7:6];
         if (o[5:0] <= 6'h31)
            e_val = o[5:0];
      end
      if (c)
         e_crc = 1;
      q.push_back({e_par, e_crc, e_eq, e_sp, e_en, e_rg, e_val});
      #1;
      chk("command", 17'({cmd_blocked, cmd_execute}), 17'({blk, !blk}));
      @(negedge core_clk);
      {go, bad, crc_error} = 3'h0;
      chk("mode five", 17'({parity_latency, parity_latency_clocks, persistent_mode, vref_probe_enable}),
         17'({e_lat, (e_lat == 0) ? 4'h0 : 4'(e_lat) + 4'h3, e_pers, e_en}));
      @(negedge core_clk);
   endtask : cmd
   always @(posedge core_clk) begin
      if (q.size() > 0) begin
         #1;
         chk("regs", obs, q.pop_front());
      end
   end
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 400) begin
         bad_count++;
         wrap_up();
      end
   end
   initial begin
      void'($urandom(80955));
      repeat (5) @(negedge core_clk);
      reset_n = 1;
      chk("reset", obs, 17'h00400);
      for (int s = 0; s < 8; s++)
         cmd(m6(s[2:0]), 0, 0);
      $display("test mode six fields done");
      for (int s = 0; s < 5; s++)
         cmd({1'b0, 3'(s), 18'($urandom)} & 22'h1C3FFF, 0, s == 0);
      $display("test other selects done");
      cmd(22'h140001, 0, 0);
      cmd(m6(3'h2), 1, 0);
      cmd(m6(3'h3), 1, 0);
      cmd(22'h140211, 0, 0);
      cmd(m6(3'h1), 1, 0);
      cmd(22'h140001, 0, 0);
      $display("test parity and clear done");
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
